// *** core/crsc_pkg.sv ***
/*
 Shared constants and types of the clock rate and step control block.
 Assumes a 50 MHz pclk and an APB master with 32-bit data.
*/
package crsc_pkg;

	localparam int CLK_HZ = 50_000_000;
	localparam int SRC_HZ = 500_000;
	localparam int OSC_DIV = CLK_HZ / SRC_HZ;
	localparam int STEP_CPS_MIN = 5;
	localparam int STEP_CPS_MAX = 35;
	localparam logic [5:0] STEP_CPS_RST = 6'h14;

	localparam logic [11:0] ADDR_CMD = 12'h000;
	localparam logic [11:0] ADDR_STATUS = 12'h004;
	localparam logic [11:0] ADDR_STEP_RATE = 12'h008;
	localparam logic [11:0] ADDR_PULSE_CNT = 12'h00C;

	localparam int CMD_SEL_NORMAL = 0;
	localparam int CMD_SEL_TEST = 1;
	localparam int CMD_MODE_REL = 2;
	localparam int CMD_SEL_DRUM = 3;
	localparam int CMD_SEL_OSC = 4;
	localparam int CMD_SRC_REL = 5;
	localparam int CMD_RATE_REL = 6;
	localparam int CMD_START = 7;
	localparam int CMD_STEP = 8;
	localparam int CMD_STOP = 9;
	localparam int CMD_RATE_LSB = 10;
	localparam int CMD_RATE_SET = 13;

	localparam logic [2:0] RATE_HIGH = 3'h0;
	localparam logic [2:0] RATE_MSTEP_OP = 3'h1;
	localparam logic [2:0] RATE_MSTEP_CLK = 3'h2;
	localparam logic [2:0] RATE_MSTEP_DIST = 3'h3;
	localparam logic [2:0] RATE_ASTEP_CLK = 3'h4;
	localparam logic [2:0] RATE_ASTEP_OP = 3'h5;

	localparam int PIN_DRUM = 0;
	localparam int PIN_STEP = 1;
	localparam int PIN_ADV = 2;
	localparam int PIN_WAIT = 3;
	localparam int PIN_RESUME = 4;
	localparam int PIN_EOI = 5;
	localparam int PIN_STOP = 6;
	localparam int PIN_N = 7;

	typedef enum logic [1:0] {MODE_NONE, MODE_NORMAL, MODE_TEST} crsc_mode_type;
	typedef enum logic [2:0] {GATE_OFF, GATE_TO_ADV, GATE_TO_EOI, GATE_CONT} crsc_gate_type;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} crsc_apb_req_type;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} crsc_apb_rsp_type;

endpackage

// *** core/crsc_top.sv ***
/*
 Clock rate and step control: selects the 500 kc source, gates controlled
 pulses continuously, singly or in bursts, and interlocks panel selections.
 Assumes distributor and panel pins are asynchronous to pclk.
*/
`timescale 1ns/1ns
module crsc_top #(
	parameter int STEP_ACC_LIMIT = crsc_pkg::CLK_HZ
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire crsc_pkg::crsc_apb_req_type apb_req,
	output crsc_pkg::crsc_apb_rsp_type apb_rsp,
	input wire logic drum_clock_pin,
	input wire logic step_button_pin,
	input wire logic distributor_advance_pin,
	input wire logic wait_pin,
	input wire logic resume_pin,
	input wire logic end_of_instruction_pulse_pin,
	input wire logic stop_pin,
	output logic controlled_clock_pulse,
	output logic dist_stop,
	output logic ready,
	output logic operating,
	output logic clock_source_drum,
	output logic step_osc_enable,
	output logic addr_counter_manual_enable,
	output logic panel_set_enable,
	output logic mt_write_test_enable
);

	typedef struct packed {
		logic [crsc_pkg::PIN_N-1:0] s1;
		logic [crsc_pkg::PIN_N-1:0] s2;
		logic [crsc_pkg::PIN_N-1:0] s3;
		logic [6:0] osc_cnt;
		logic [25:0] acc;
		crsc_pkg::crsc_mode_type mode;
		logic src_held;
		logic src_drum;
		logic rate_valid;
		logic [2:0] rate;
		logic op;
		logic dist_stop;
		crsc_pkg::crsc_gate_type gate;
		logic pend;
		logic wait_hold;
		logic cc;
		logic [5:0] step_cps;
		logic [15:0] pulse_cnt;
		logic ready;
		logic osc_en;
		logic addr_cnt_en;
		logic set_en;
		logic mtw_en;
		crsc_pkg::crsc_apb_rsp_type rsp;
	} crsc_state_type;

	crsc_state_type st_q;
	crsc_state_type st_d;

	logic [crsc_pkg::PIN_N-1:0] pins;
	logic [crsc_pkg::PIN_N-1:0] rise;
	logic setup;
	logic wr;
	logic [31:0] cmd;
	logic src_tick;
	logic auto_tick;
	logic trig;
	logic stop_ev;
	logic auto_mode;
	logic [26:0] acc_sum;
	logic [31:0] rdata;
	logic hit;

	assign pins = {stop_pin, end_of_instruction_pulse_pin, resume_pin, wait_pin,
		distributor_advance_pin, step_button_pin, drum_clock_pin};

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		st_d = st_q;
		// Pin synchronisers and edge detect
		st_d.s1 = pins;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
		rise = st_q.s2 & ~st_q.s3;

		setup = apb_req.psel & ~apb_req.penable;
		wr = apb_req.psel & apb_req.penable & st_q.rsp.pready & apb_req.pwrite;
		cmd = (wr && apb_req.paddr == crsc_pkg::ADDR_CMD) ? apb_req.pwdata : 32'h0;

		// Local 500 kc oscillator
		if (st_q.osc_cnt == 7'(crsc_pkg::OSC_DIV - 1)) begin
			st_d.osc_cnt = 7'h00;
		end else begin
			st_d.osc_cnt = st_q.osc_cnt + 7'h01;
		end
		// Selected source tick
		src_tick = st_q.src_drum ? rise[crsc_pkg::PIN_DRUM] : (st_q.osc_cnt == 7'h00);

		// Step oscillator, rate in cycles per second
		auto_mode = st_q.rate_valid &&
			(st_q.rate == crsc_pkg::RATE_ASTEP_CLK || st_q.rate == crsc_pkg::RATE_ASTEP_OP);
		acc_sum = {1'b0, st_q.acc} + {21'h0, st_q.step_cps};
		auto_tick = 1'b0;
		if (!st_q.osc_en) begin
			st_d.acc = 26'h0;
		end else if (acc_sum >= 27'(STEP_ACC_LIMIT)) begin
			st_d.acc = 26'(acc_sum - 27'(STEP_ACC_LIMIT));
			auto_tick = 1'b1;
		end else begin
			st_d.acc = acc_sum[25:0];
		end

		// Mode selection
		if (!st_q.op) begin
			if (cmd[crsc_pkg::CMD_MODE_REL]) begin
				st_d.mode = crsc_pkg::MODE_NONE;
			end else if (st_q.mode == crsc_pkg::MODE_NONE && cmd[crsc_pkg::CMD_SEL_NORMAL]) begin
				st_d.mode = crsc_pkg::MODE_NORMAL;
				st_d.src_held = 1'b1;
				st_d.src_drum = 1'b1;
				st_d.rate_valid = 1'b1;
				st_d.rate = crsc_pkg::RATE_HIGH;
			end else if (st_q.mode == crsc_pkg::MODE_NONE && cmd[crsc_pkg::CMD_SEL_TEST]) begin
				st_d.mode = crsc_pkg::MODE_TEST;
			end
			// Clock source selection
			if (cmd[crsc_pkg::CMD_SRC_REL]) begin
				st_d.src_held = 1'b0;
			end else if (!st_q.src_held && st_q.mode == crsc_pkg::MODE_TEST) begin
				if (cmd[crsc_pkg::CMD_SEL_DRUM]) begin
					st_d.src_held = 1'b1;
					st_d.src_drum = 1'b1;
				end else if (cmd[crsc_pkg::CMD_SEL_OSC]) begin
					st_d.src_held = 1'b1;
					st_d.src_drum = 1'b0;
				end
			end
			// Rate selection
			if (cmd[crsc_pkg::CMD_RATE_REL]) begin
				st_d.rate_valid = 1'b0;
			end else if (cmd[crsc_pkg::CMD_RATE_SET] && st_q.mode == crsc_pkg::MODE_TEST &&
				cmd[crsc_pkg::CMD_RATE_LSB+:3] <= crsc_pkg::RATE_ASTEP_OP) begin
				st_d.rate_valid = 1'b1;
				st_d.rate = cmd[crsc_pkg::CMD_RATE_LSB+:3];
			end
		end

		// Step rate register
		if (wr && apb_req.paddr == crsc_pkg::ADDR_STEP_RATE) begin
			if (apb_req.pwdata[5:0] < 6'(crsc_pkg::STEP_CPS_MIN)) begin
				st_d.step_cps = 6'(crsc_pkg::STEP_CPS_MIN);
			end else if (apb_req.pwdata[5:0] > 6'(crsc_pkg::STEP_CPS_MAX)) begin
				st_d.step_cps = 6'(crsc_pkg::STEP_CPS_MAX);
			end else begin
				st_d.step_cps = apb_req.pwdata[5:0];
			end
		end

		// Start and stop
		stop_ev = rise[crsc_pkg::PIN_STOP] | cmd[crsc_pkg::CMD_STOP];
		trig = 1'b0;
		if (stop_ev) begin
			st_d.op = 1'b0;
			st_d.dist_stop = 1'b1;
			st_d.gate = crsc_pkg::GATE_OFF;
			st_d.pend = 1'b0;
		end else if (!st_q.op && st_q.ready && cmd[crsc_pkg::CMD_START]) begin
			st_d.op = 1'b1;
			st_d.dist_stop = 1'b0;
			st_d.wait_hold = 1'b0;
			trig = (st_q.rate == crsc_pkg::RATE_HIGH);
		end else if (st_q.op) begin
			unique case (st_q.rate)
				crsc_pkg::RATE_HIGH: trig = 1'b0;
				crsc_pkg::RATE_ASTEP_CLK, crsc_pkg::RATE_ASTEP_OP: trig = auto_tick;
				default: trig = rise[crsc_pkg::PIN_STEP] | cmd[crsc_pkg::CMD_STEP];
			endcase
		end
		if (trig && st_q.gate == crsc_pkg::GATE_OFF) begin
			st_d.pend = 1'b1;
		end

		// Wait holds off the advance until resume
		if (rise[crsc_pkg::PIN_WAIT]) begin
			st_d.wait_hold = 1'b1;
		end else if (rise[crsc_pkg::PIN_RESUME]) begin
			st_d.wait_hold = 1'b0;
		end

		// Burst end conditions
		if (!stop_ev) begin
			unique case (st_q.gate)
				crsc_pkg::GATE_TO_ADV: begin
					if (rise[crsc_pkg::PIN_ADV] && !st_q.wait_hold) begin
						st_d.gate = crsc_pkg::GATE_OFF;
					end
				end
				crsc_pkg::GATE_TO_EOI: begin
					if (rise[crsc_pkg::PIN_EOI]) begin
						st_d.gate = crsc_pkg::GATE_OFF;
					end
				end
				default: begin
				end
			endcase
		end

		// Gate acts on whole source pulses only
		st_d.cc = 1'b0;
		if (src_tick && st_q.op && !stop_ev) begin
			if (st_d.gate != crsc_pkg::GATE_OFF) begin
				st_d.cc = 1'b1;
			end else if (st_q.pend) begin
				st_d.cc = 1'b1;
				st_d.pend = 1'b0;
				unique case (st_q.rate)
					crsc_pkg::RATE_HIGH: st_d.gate = crsc_pkg::GATE_CONT;
					crsc_pkg::RATE_MSTEP_DIST: st_d.gate = crsc_pkg::GATE_TO_ADV;
					crsc_pkg::RATE_MSTEP_OP, crsc_pkg::RATE_ASTEP_OP: st_d.gate = crsc_pkg::GATE_TO_EOI;
					default: st_d.gate = crsc_pkg::GATE_OFF;
				endcase
			end
		end
		if (st_d.cc) begin
			st_d.pulse_cnt = st_q.pulse_cnt + 16'h0001;
		end

		// Registered panel outputs
		st_d.ready = st_d.mode != crsc_pkg::MODE_NONE && st_d.src_held && st_d.rate_valid;
		st_d.osc_en = auto_mode && st_d.op;
		st_d.addr_cnt_en = !st_d.op;
		st_d.set_en = st_d.mode == crsc_pkg::MODE_TEST && st_d.ready;
		st_d.mtw_en = st_d.mode != crsc_pkg::MODE_NORMAL;

		// APB read data, prepared in the setup cycle
		hit = 1'b1;
		unique case (apb_req.paddr)
			crsc_pkg::ADDR_CMD: rdata = 32'h0;
			crsc_pkg::ADDR_STATUS: rdata = {16'h0, st_q.wait_hold, st_q.dist_stop, 1'b0,
				st_q.gate, st_q.op, st_q.ready, st_q.rate, st_q.rate_valid,
				st_q.src_drum, st_q.src_held, st_q.mode};
			crsc_pkg::ADDR_STEP_RATE: rdata = {26'h0, st_q.step_cps};
			crsc_pkg::ADDR_PULSE_CNT: rdata = {16'h0, st_q.pulse_cnt};
			default: begin
				rdata = 32'h0;
				hit = 1'b0;
			end
		endcase
		st_d.rsp.pready = setup;
		st_d.rsp.pslverr = setup & ~hit;
		st_d.rsp.prdata = (setup && !apb_req.pwrite) ? rdata : 32'h0;
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= '{s1: '0, s2: '0, s3: '0, osc_cnt: 7'h00, acc: 26'h0,
				mode: crsc_pkg::MODE_NONE, src_held: 1'b0, src_drum: 1'b1,
				rate_valid: 1'b0, rate: crsc_pkg::RATE_HIGH, op: 1'b0,
				dist_stop: 1'b1, gate: crsc_pkg::GATE_OFF, pend: 1'b0,
				wait_hold: 1'b0, cc: 1'b0, step_cps: crsc_pkg::STEP_CPS_RST,
				pulse_cnt: 16'h0000, ready: 1'b0, osc_en: 1'b0, addr_cnt_en: 1'b1,
				set_en: 1'b0, mtw_en: 1'b1, rsp: '0};
		end else begin
			st_q <= st_d;
		end
	end

	assign apb_rsp = st_q.rsp;
	assign controlled_clock_pulse = st_q.cc;
	assign dist_stop = st_q.dist_stop;
	assign ready = st_q.ready;
	assign operating = st_q.op;
	assign clock_source_drum = st_q.src_drum;
	assign step_osc_enable = st_q.osc_en;
	assign addr_counter_manual_enable = st_q.addr_cnt_en;
	assign panel_set_enable = st_q.set_en;
	assign mt_write_test_enable = st_q.mtw_en;

endmodule

// *** dv/crsc_panel_model.sv ***
/*
 Panel and distributor model: drum track pulses and advance/end of instruction.
 Assumes the bench sets burst to zero between scenarios.
*/
`timescale 1ns/1ns
module crsc_panel_model (
	input wire logic pclk,
	input wire logic controlled_clock_pulse,
	input wire logic drum_on,
	input wire logic [7:0] burst,
	output logic drum_clock_pin = 1'b0,
	output logic done_pin
);
	int ph = 0;
	int n = 0;
	int hold = 0;
	// Drum track, still while off
	always @(posedge pclk) begin
		ph <= drum_on ? (ph + 1) % 100 : 0;
		drum_clock_pin <= drum_on && ph >= 50;
	end
	// Advance or end of instruction after burst pulses
	always @(posedge pclk) begin
		if (hold != 0) hold <= hold - 1;
		if (burst == 8'h00) begin
			n <= 0;
		end else if (n == burst) begin
			n <= 0;
			hold <= 4;
		end else if (controlled_clock_pulse) begin
			n <= n + 1;
		end
	end
	assign done_pin = hold != 0;
endmodule

// *** dv/crsc_props.sv ***
/*
 Checker of crsc_top outputs.
 Assumes one pclk domain, presetn active low.
*/
`timescale 1ns/1ns
module crsc_props #(
	parameter int STEP_ACC_LIMIT = crsc_pkg::CLK_HZ
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic controlled_clock_pulse,
	input wire logic dist_stop,
	input wire logic ready,
	input wire logic operating,
	input wire logic clock_source_drum,
	input wire logic step_osc_enable,
	input wire logic addr_counter_manual_enable,
	input wire logic panel_set_enable,
	input wire logic mt_write_test_enable
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////////
	a_pulse_whole: assert property (controlled_clock_pulse |=> !controlled_clock_pulse [*8])
		else $error("pulse too long");
	a_pulse_in_run: assert property (controlled_clock_pulse |-> operating || $past(operating))
		else $error("pulse while idle");
	a_start_ready: assert property ($rose(operating) |-> $past(ready))
		else $error("start without ready");
	a_start_clears: assert property ($rose(operating) |-> ##[0:2] !dist_stop)
		else $error("stop flop not cleared");
	a_counter_locked: assert property (operating |-> !addr_counter_manual_enable)
		else $error("counter not locked");
	a_counter_free: assert property (!operating |-> addr_counter_manual_enable)
		else $error("counter not free");
	a_normal_drum: assert property (!mt_write_test_enable |-> clock_source_drum)
		else $error("normal without drum");
	a_held_in_run: assert property (operating && $past(operating) |-> $stable(mt_write_test_enable)
		&& $stable(clock_source_drum))
		else $error("selection changed in run");
	a_osc_in_run: assert property (step_osc_enable |-> operating || $past(operating))
		else $error("step oscillator while idle");
	a_panel_test: assert property (panel_set_enable |-> mt_write_test_enable)
		else $error("panel enable in normal");
	c_osc_pulse: cover property (controlled_clock_pulse && !clock_source_drum);
	c_run: cover property ($rose(operating));
	c_auto: cover property (step_osc_enable && controlled_clock_pulse);
endmodule
bind crsc_top crsc_props #(.STEP_ACC_LIMIT(STEP_ACC_LIMIT)) u_props (.pclk, .presetn, .controlled_clock_pulse,
	.dist_stop, .ready, .operating, .clock_source_drum, .step_osc_enable, .addr_counter_manual_enable,
	.panel_set_enable, .mt_write_test_enable);

// *** dv/tb_clock_rate_and_step_control.sv ***
/*
 Testbench of crsc_top: APB tasks, scenario tasks, and some scenarios run inline in the initial block.
 Assumes crsc_panel_model as drum and distributor.
*/
`timescale 1ns/1ns
module tb_clock_rate_and_step_control;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	crsc_pkg::crsc_apb_req_type req = '0;
	crsc_pkg::crsc_apb_rsp_type rsp;
	logic [3:0] pin = 4'h0;
	logic drum_on = 1'b0;
	logic [7:0] burst = 8'h00;
	logic done, ccp, drum, dstop, rdy, op, srcd, osc, acen, pse, mtw, rerr;
	logic [31:0] rdat;
	int n_errors = 0;
	int comparisons = 0;
	int pulses = 0;
	int base;
	always #10 pclk = ~pclk;
	always @(posedge pclk) if (ccp) pulses <= pulses + 1;
	crsc_top #(.STEP_ACC_LIMIT(2000)) u_dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
		.drum_clock_pin(drum), .step_button_pin(pin[0]), .distributor_advance_pin(done), .wait_pin(pin[1]),
		.resume_pin(pin[2]), .end_of_instruction_pulse_pin(done), .stop_pin(pin[3]),
		.controlled_clock_pulse(ccp), .dist_stop(dstop), .ready(rdy), .operating(op), .clock_source_drum(srcd),
		.step_osc_enable(osc), .addr_counter_manual_enable(acen), .panel_set_enable(pse),
		.mt_write_test_enable(mtw));
	crsc_panel_model u_panel (.pclk(pclk), .controlled_clock_pulse(ccp), .drum_on(drum_on), .burst(burst),
		.drum_clock_pin(drum), .done_pin(done));
	////////////////////////////////////////////////////////////////
	task automatic wrap_up();
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge pclk);
		req.penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (rsp.pready !== 1'b1 && k < 20);
		if (rsp.pready !== 1'b1) begin
			n_errors++;
			wrap_up();
		end
		rdat = rsp.prdata;
		rerr = rsp.pslverr;
		req <= '0;
		@(posedge pclk);
	endtask
	task automatic cmd(input int b);
		bus(1'b1, crsc_pkg::ADDR_CMD, 32'h1 << b);
	endtask
	task automatic rate(input logic [2:0] c);
		bus(1'b1, crsc_pkg::ADDR_CMD, {18'h0, 1'b1, c, 10'h0});
	endtask
	task automatic st();
		bus(1'b0, crsc_pkg::ADDR_STATUS, 32'h0);
	endtask
	task automatic press(input int i);
		pin[i] <= 1'b1;
		wt(4);
		pin[i] <= 1'b0;
		wt(6);
	endtask
	task automatic go(input int who, input int n, input int lo, input int hi);
		base = pulses;
		if (who >= 0 && who < 4) press(who);
		if (who == 8) cmd(crsc_pkg::CMD_STEP);
		wt(n);
		chk(pulses - base >= lo && pulses - base <= hi, 1);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_reset();
		chk({dstop, srcd, acen, mtw, rdy, op, pse, osc, ccp}, 9'h1E0);
		bus(1'b0, crsc_pkg::ADDR_STEP_RATE, 32'h0);
		chk(rdat, 32'h14);
		bus(1'b0, 12'h010, 32'h0);
		chk({rdat, rerr}, 33'h1);
	endtask
	task automatic t_normal();
		cmd(crsc_pkg::CMD_SEL_NORMAL);
		cmd(crsc_pkg::CMD_SEL_TEST);
		st();
		chk(rdat[8:0], 9'h11D);
		chk(mtw, 1'b0);
		drum_on <= 1'b1;
		cmd(crsc_pkg::CMD_START);
		wt(2);
		chk({op, dstop, acen}, 3'h4);
		go(0, 1000, 9, 11);
		cmd(crsc_pkg::CMD_MODE_REL);
		press(3);
		go(-1, 500, 0, 0);
		st();
		chk(rdat[1:0], 2'h1);
	endtask
	task automatic t_test();
		cmd(crsc_pkg::CMD_MODE_REL);
		cmd(crsc_pkg::CMD_SRC_REL);
		cmd(crsc_pkg::CMD_RATE_REL);
		cmd(crsc_pkg::CMD_SEL_TEST);
		drum_on <= 1'b0;
		cmd(crsc_pkg::CMD_SEL_OSC);
		cmd(crsc_pkg::CMD_SEL_DRUM);
		chk(srcd, 1'b0);
		for (int c = 0; c < 8; c++) begin
			rate(c[2:0]);
			st();
			chk(rdat[7:5], c < 6 ? c[2:0] : 3'h5);
		end
		chk(rdat[8], 1'b1);
		chk({rdy, pse, mtw}, 3'h7);
	endtask
	task automatic t_run(input logic [2:0] r, input logic [7:0] b, input int who, n, lo, hi);
		rate(r);
		burst <= b;
		cmd(crsc_pkg::CMD_START);
		go(who, n, lo, hi);
	endtask
	task automatic t_stop();
		press(3);
		burst <= 8'h00;
		wt(2);
		chk({op, dstop, acen}, 3'h3);
	endtask
	initial begin
		wt(20);
		presetn <= 1'b1;
		wt(1);
		t_reset();
		t_normal();
		t_test();
		t_run(crsc_pkg::RATE_MSTEP_CLK, 8'h00, 0, 300, 1, 1);
		rate(crsc_pkg::RATE_HIGH);
		st();
		chk(rdat[7:5], 3'h2);
		go(0, 300, 1, 1);
		t_stop();
		t_run(crsc_pkg::RATE_MSTEP_OP, 8'h03, 8, 800, 3, 3);
		t_stop();
		t_run(crsc_pkg::RATE_MSTEP_DIST, 8'h01, 0, 400, 1, 1);
		press(1);
		go(8, 1000, 8, 11);
		go(2, 500, 1, 2);
		t_stop();
		bus(1'b1, crsc_pkg::ADDR_STEP_RATE, 32'h5);
		t_run(crsc_pkg::RATE_ASTEP_CLK, 8'h00, -1, 4000, 8, 11);
		chk(osc, 1'b1);
		t_stop();
		t_run(crsc_pkg::RATE_ASTEP_OP, 8'h02, -1, 4000, 16, 22);
		t_stop();
		wrap_up();
	end
	initial begin
		#2000000;
		n_errors++;
		wrap_up();
	end
endmodule
